/* reload_down_timer_unit.v */
// Five independent reload timers with an Avalon-MM register slave and interrupt.
//
// Operation
// - Five independent 16-bit timer channels.
// - Two-bit mode field picks timer, event, one-shot or PWM; timer mode is built.
// - Timer source is clock, clock/2, /8, /32 or subclock/32.
// - Counter decrements per source pulse and reloads on underflow.
// - Value n gives one underflow every n+1 source pulses.
// - Start bit 1 starts a channel, 0 halts it.
// - Each underflow raises the channel interrupt request.
// - Reading the count register returns the live counter.
// - Writes load counter and reload while stopped or before first pulse.
// - After counting begins, writes load only reload, taken at next reload.
// - With gate selected, input pin level enables counting.
// - With pulse output selected, output pin toggles at each underflow.
// - Pulse output is held low while the start bit is 0.
// - Input pin is port or gate; output pin is port or pulse output.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "reload_timer_consts.vh"
module reload_down_timer_unit #(
    parameter NUM_CH = 5
) (
    input wire clk,
    input wire reset,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire subclock,
    input wire [NUM_CH-1:0] channel_input_pin,
    output wire [NUM_CH-1:0] channel_output_pin,
    output reg [NUM_CH-1:0] channel_output_pin_oe,
    output reg irq
);
    reg [`PRESC_WIDTH-1:0] presc_reg;
    reg [`PRESC_WIDTH-1:0] sub_div_reg;
    reg sub_meta_reg;
    reg sub_sync_reg;
    reg sub_last_reg;
    reg sub_tick_reg;
    reg [NUM_CH-1:0] pin_meta_reg;
    reg [NUM_CH-1:0] pin_sync_reg;
    reg [NUM_CH-1:0] run_reg;
    reg [`MODE_WIDTH-1:0] mode_reg [0:NUM_CH-1];
    reg [NUM_CH-1:0] status_reg;
    reg [NUM_CH-1:0] status_next;
    reg [NUM_CH-1:0] mask_reg;
    reg [31:0] read_mux;
    reg [NUM_CH-1:0] wr_count_vec;
    reg hit_start;
    reg hit_status;
    reg hit_mask;
    reg hit_pins;
    reg hit_state;
    reg [NUM_CH-1:0] hit_count;
    reg [NUM_CH-1:0] hit_mode;
    reg [NUM_CH-1:0] status_clear;
    reg [NUM_CH-1:0] timer_mode_vec;
    reg [NUM_CH-1:0] pulse_en_vec;
    reg [NUM_CH-1:0] gate_open_vec;
    reg [NUM_CH-1:0] tick_vec;
    reg [16*NUM_CH-1:0] wr_data_flat;
    wire [4:0] src_ticks;
    wire take_access;
    wire do_write;
    wire do_read;
    wire wr_shared;
    wire [NUM_CH-1:0] underflow_vec;
    wire [NUM_CH-1:0] started_vec;
    wire [16*NUM_CH-1:0] count_flat;
    wire [16*NUM_CH-1:0] reload_flat;
    integer k;
    integer kd;
    integer kw;
    integer kx;
    integer km;
    integer ko;
    integer kc;

    // Byte address of a channel register.
    function [7:0] chan_addr;
        input integer idx;
        input reg is_mode;
        begin
            chan_addr = `CHAN_BASE_OFS + (`CHAN_STRIDE * idx[7:0])
                + (is_mode ? `CHAN_MODE_DELTA : 8'h00);
        end
    endfunction

    // Merge the low two write lanes into a 16-bit value.
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] be;
        begin
            merge16[7:0] = be[0] ? data[7:0] : old[7:0];
            merge16[15:8] = be[1] ? data[15:8] : old[15:8];
        end
    endfunction

    // Pick the strobe of the selected count source.
    function pick_tick;
        input [2:0] sel;
        input [4:0] ticks;
        begin
            case (sel)
                `SRC_DIV1: pick_tick = ticks[0];
                `SRC_DIV2: pick_tick = ticks[1];
                `SRC_DIV8: pick_tick = ticks[2];
                `SRC_DIV32: pick_tick = ticks[3];
                `SRC_SUB32: pick_tick = ticks[4];
                default: pick_tick = 1'b0;
            endcase
        end
    endfunction

    // Strobes stay one cycle wide so every counter update is a plain clocked step.
    always @(posedge clk) begin
        if (reset) begin
            presc_reg <= {`PRESC_WIDTH{1'b0}};
        end else begin
            presc_reg <= presc_reg + 5'h01;
        end
    end

    assign src_ticks[0] = 1'b1;
    assign src_ticks[1] = ((presc_reg & `DIV2_MASK) == `DIV2_MASK);
    assign src_ticks[2] = ((presc_reg & `DIV8_MASK) == `DIV8_MASK);
    assign src_ticks[3] = (presc_reg == `DIV32_MASK);
    assign src_ticks[4] = sub_tick_reg;

    // The subclock is slow and unrelated, so its rising edges are counted after a synchroniser.
    always @(posedge clk) begin
        if (reset) begin
            sub_meta_reg <= 1'b0;
            sub_sync_reg <= 1'b0;
            sub_last_reg <= 1'b0;
            sub_div_reg <= {`PRESC_WIDTH{1'b0}};
            sub_tick_reg <= 1'b0;
        end else begin
            sub_meta_reg <= subclock;
            sub_sync_reg <= sub_meta_reg;
            sub_last_reg <= sub_sync_reg;
            sub_tick_reg <= 1'b0;
            if (sub_sync_reg && !sub_last_reg) begin
                sub_div_reg <= sub_div_reg + 5'h01;
                sub_tick_reg <= (sub_div_reg == `SUB_DIV_LAST);
            end
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            pin_meta_reg <= {NUM_CH{1'b0}};
            pin_sync_reg <= {NUM_CH{1'b0}};
        end else begin
            pin_meta_reg <= channel_input_pin;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Each access is answered with waitrequest low in the second cycle of the request.
    assign take_access = (avs_read | avs_write) & ~avs_waitrequest;
    assign do_write = take_access & avs_write;
    assign do_read = take_access & avs_read;
    assign wr_shared = do_write & avs_byteenable[0];

    always @(posedge clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
        end
    end

    // The address is held for the whole access, so one decode serves both cycles.
    always @* begin
        hit_start = (avs_address == `START_FLAG_OFS);
        hit_status = (avs_address == `IRQ_STATUS_OFS);
        hit_mask = (avs_address == `IRQ_MASK_OFS);
        hit_pins = (avs_address == `PIN_LEVEL_OFS);
        hit_state = (avs_address == `CHAN_STATE_OFS);
        for (kd = 0; kd < NUM_CH; kd = kd + 1) begin
            hit_count[kd] = (avs_address == chan_addr(kd, 1'b0));
            hit_mode[kd] = (avs_address == chan_addr(kd, 1'b1));
        end
    end

    always @* begin
        read_mux = 32'h00000000;
        if (hit_start) begin
            read_mux[NUM_CH-1:0] = run_reg;
        end
        if (hit_status) begin
            read_mux[NUM_CH-1:0] = status_reg;
        end
        if (hit_mask) begin
            read_mux[NUM_CH-1:0] = mask_reg;
        end
        if (hit_pins) begin
            read_mux[NUM_CH-1:0] = pin_sync_reg;
        end
        if (hit_state) begin
            read_mux[NUM_CH-1:0] = started_vec;
        end
        for (k = 0; k < NUM_CH; k = k + 1) begin
            if (hit_count[k]) begin
                read_mux[15:0] = count_flat[16*k +: 16];
            end
            if (hit_mode[k]) begin
                read_mux[`MODE_WIDTH-1:0] = mode_reg[k];
            end
        end
    end

    // Read data is taken while waitrequest is high and stands through the answer cycle.
    always @(posedge clk) begin
        if (reset) begin
            avs_readdata <= 32'h00000000;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_readdata <= avs_read ? read_mux : 32'h00000000;
        end
    end

    always @* begin
        for (kw = 0; kw < NUM_CH; kw = kw + 1) begin
            wr_count_vec[kw] = do_write && hit_count[kw];
        end
    end

    // Partial writes keep the other byte of the live counter.
    always @* begin
        for (kx = 0; kx < NUM_CH; kx = kx + 1) begin
            wr_data_flat[16*kx +: 16] = merge16(count_flat[16*kx +: 16], avs_writedata,
                avs_byteenable);
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            run_reg <= {NUM_CH{1'b0}};
        end else if (wr_shared && hit_start) begin
            run_reg <= avs_writedata[NUM_CH-1:0];
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            mask_reg <= `MASK_RESET;
        end else if (wr_shared && hit_mask) begin
            mask_reg <= avs_writedata[NUM_CH-1:0];
        end
    end

    always @(posedge clk) begin
        for (km = 0; km < NUM_CH; km = km + 1) begin
            if (reset) begin
                mode_reg[km] <= `MODE_RESET;
            end else if (wr_shared && hit_mode[km]) begin
                mode_reg[km] <= avs_writedata[`MODE_WIDTH-1:0];
            end
        end
    end

    // Only the bits already shown to the reader are cleared.
    // An underflow that lands between the two cycles of the read is kept.
    // A new underflow in the clearing cycle stays set.
    always @* begin
        status_clear = {NUM_CH{1'b0}};
        if (do_read && hit_status) begin
            status_clear = avs_readdata[NUM_CH-1:0];
        end
    end

    always @* begin
        status_next = (status_reg & ~status_clear) | underflow_vec;
    end

    always @(posedge clk) begin
        if (reset) begin
            status_reg <= {NUM_CH{1'b0}};
        end else begin
            status_reg <= status_next;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_next & mask_reg);
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            channel_output_pin_oe <= {NUM_CH{1'b0}};
        end else begin
            for (ko = 0; ko < NUM_CH; ko = ko + 1) begin
                channel_output_pin_oe[ko] <= mode_reg[ko][`MODE_PULSE_BIT];
            end
        end
    end

    // Without the gate option the input pin is a plain port and counting is free.
    always @* begin
        for (kc = 0; kc < NUM_CH; kc = kc + 1) begin
            timer_mode_vec[kc] = (mode_reg[kc][`MODE_OP_MSB:`MODE_OP_LSB] == `OP_TIMER);
            pulse_en_vec[kc] = mode_reg[kc][`MODE_PULSE_BIT];
            gate_open_vec[kc] = ~mode_reg[kc][`MODE_GATE_BIT]
                | (pin_sync_reg[kc] == mode_reg[kc][`MODE_GPOL_BIT]);
            tick_vec[kc] = pick_tick(mode_reg[kc][`MODE_SRC_MSB:`MODE_SRC_LSB],
                src_ticks);
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : chan
            timer_channel i_timer_channel (
                .clk(clk),
                .reset(reset),
                .run(run_reg[g]),
                .timer_mode(timer_mode_vec[g]),
                .tick(tick_vec[g]),
                .gate_open(gate_open_vec[g]),
                .pulse_en(pulse_en_vec[g]),
                .wr_count(wr_count_vec[g]),
                .wr_data(wr_data_flat[16*g +: 16]),
                .count_reg(count_flat[16*g +: 16]),
                .reload_reg(reload_flat[16*g +: 16]),
                .started_reg(started_vec[g]),
                .underflow_reg(underflow_vec[g]),
                .out_level_reg(channel_output_pin[g])
            );
        end
    endgenerate
endmodule // reload_down_timer_unit
`default_nettype wire

/* reload_timer_consts.vh */
// Register offsets, field positions, reset values and count sources of the reload timer unit.
`ifndef RELOAD_TIMER_CONSTS_VH
`define RELOAD_TIMER_CONSTS_VH

// Byte offsets of the shared registers.
`define START_FLAG_OFS 8'h00
`define IRQ_STATUS_OFS 8'h04
`define IRQ_MASK_OFS 8'h08
`define PIN_LEVEL_OFS 8'h0C
`define CHAN_STATE_OFS 8'h10

// Channel i: count register at CHAN_BASE + CHAN_STRIDE * i, mode register four bytes above.
`define CHAN_BASE_OFS 8'h20
`define CHAN_STRIDE 8'h08
`define CHAN_MODE_DELTA 8'h04

// Mode register fields.
`define MODE_OP_LSB 0
`define MODE_OP_MSB 1
`define MODE_PULSE_BIT 2
`define MODE_GATE_BIT 3
`define MODE_GPOL_BIT 4
`define MODE_SRC_LSB 5
`define MODE_SRC_MSB 7
`define MODE_WIDTH 8

// Operating mode codes.
`define OP_TIMER 2'h0
`define OP_EVENT 2'h1
`define OP_ONESHOT 2'h2
`define OP_PWM 2'h3

// Count source codes.
`define SRC_DIV1 3'h0
`define SRC_DIV2 3'h1
`define SRC_DIV8 3'h2
`define SRC_DIV32 3'h3
`define SRC_SUB32 3'h4

// Prescaler terminal counts.
`define PRESC_WIDTH 5
`define DIV2_MASK 5'h01
`define DIV8_MASK 5'h07
`define DIV32_MASK 5'h1F
`define SUB_DIV_LAST 5'h1F

// Reset values.
`define MODE_RESET 8'h00
`define COUNT_RESET 16'h0000
`define MASK_RESET 5'h00

`endif

/* timer_channel.v */
// One 16-bit down-counting reload timer channel in internal-count mode.
`timescale 1ns/100ps
`default_nettype none
`include "reload_timer_consts.vh"
module timer_channel (
    input wire clk,
    input wire reset,
    input wire run,
    input wire timer_mode,
    input wire tick,
    input wire gate_open,
    input wire pulse_en,
    input wire wr_count,
    input wire [15:0] wr_data,
    output reg [15:0] count_reg,
    output reg [15:0] reload_reg,
    output reg started_reg,
    output reg underflow_reg,
    output reg out_level_reg
);
    wire count_step;
    wire at_zero;

    assign count_step = run & timer_mode & tick & gate_open;
    assign at_zero = (count_reg == 16'h0000);

    always @(posedge clk) begin
        if (reset) begin
            count_reg <= `COUNT_RESET;
            reload_reg <= `COUNT_RESET;
            started_reg <= 1'b0;
            underflow_reg <= 1'b0;
        end else begin
            underflow_reg <= count_step & at_zero;
            if (!run) begin
                started_reg <= 1'b0;
            end else if (count_step) begin
                started_reg <= 1'b1;
            end
            if (wr_count) begin
                reload_reg <= wr_data;
            end
            // A write before the first counted pulse wins over that pulse.
            if (wr_count && !started_reg) begin
                count_reg <= wr_data;
            end else if (count_step) begin
                if (at_zero) begin
                    count_reg <= wr_count ? wr_data : reload_reg;
                end else begin
                    count_reg <= count_reg - 16'h0001;
                end
            end
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            out_level_reg <= 1'b0;
        end else if (!run || !pulse_en) begin
            out_level_reg <= 1'b0;
        end else if (count_step && at_zero) begin
            out_level_reg <= ~out_level_reg;
        end
    end
endmodule // timer_channel
`default_nettype wire

/* reload_timer_assertions.sv */
// Port-level checker for the reload timer unit.
`timescale 1ns/100ps
`default_nettype none
`include "reload_timer_consts.vh"
module reload_timer_checker #(
    parameter NUM_CH = 5
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic subclock,
    input wire logic [NUM_CH-1:0] channel_input_pin,
    input wire logic [NUM_CH-1:0] channel_output_pin,
    input wire logic [NUM_CH-1:0] channel_output_pin_oe,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic req = avs_read | avs_write;
    wire logic ack = req & ~avs_waitrequest;
    wire logic wr0 = ack & avs_write & avs_byteenable[0];
    wire logic umap = avs_address[1:0] == 2'h0 && avs_address >= 8'h14
        && (avs_address < `CHAN_BASE_OFS || avs_address >= 8'h48);
    logic [NUM_CH-1:0] sf_held;
    logic [NUM_CH-1:0] mask_held;
    // Shadows of the start flags and mask, so pin and irq checks need no internal state.
    always_ff @(posedge clk) begin
        if (reset) begin
            sf_held <= '0;
            mask_held <= '0;
        end else if (wr0 && avs_address == `START_FLAG_OFS) begin
            sf_held <= avs_writedata[NUM_CH-1:0];
        end else if (wr0 && avs_address == `IRQ_MASK_OFS) begin
            mask_held <= avs_writedata[NUM_CH-1:0];
        end
    end
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest did not drop");
    a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_idle_wait: assert property (!req |=> avs_waitrequest)
        else $error("answer without request");
    a_unmapped_zero: assert property (ack && avs_read && umap |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_count_upper: assert property (ack && avs_read && avs_address >= `CHAN_BASE_OFS
        |-> avs_readdata[31:16] == 16'h0000)
        else $error("count read upper bits set");
    a_flags_upper: assert property (ack && avs_read && avs_address < 8'h14
        |-> avs_readdata[31:NUM_CH] == '0)
        else $error("flag read upper bits set");
    a_mask_off: assert property (wr0 && avs_address == `IRQ_MASK_OFS
        && avs_writedata[NUM_CH-1:0] == '0 |=> ##1 !irq)
        else $error("irq high with mask clear");
    a_irq_masked: assert property (irq |-> (mask_held | $past(mask_held)) != '0)
        else $error("irq with no mask bit");
    a_stop_low: assert property (wr0 && avs_address == `START_FLAG_OFS
        |=> ##1 (channel_output_pin & ~sf_held) == '0)
        else $error("stopped channel pin high");
    c_irq: cover property (irq);
    c_unmapped: cover property (ack && avs_read && umap);
    c_toggle: cover property ($rose(channel_output_pin[0]));
endmodule // reload_timer_checker
bind reload_down_timer_unit reload_timer_checker #(.NUM_CH(NUM_CH)) i_reload_timer_checker (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .subclock(subclock),
    .channel_input_pin(channel_input_pin), .channel_output_pin(channel_output_pin),
    .channel_output_pin_oe(channel_output_pin_oe), .irq(irq));
`default_nettype wire

/* test_reload_down_timer_unit.sv */
// Self-checking bench for the reload timer unit.
`timescale 1ns/100ps
`default_nettype none
`include "reload_timer_consts.vh"
module test_reload_down_timer_unit;
    logic clk = 0;
    logic reset = 1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = 32'h0;
    logic [1:0] sub_cnt = 2'h0;
    logic subclock = 0;
    logic [4:0] channel_input_pin = 5'h00;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire irq;
    wire [4:0] channel_output_pin;
    wire [4:0] channel_output_pin_oe;
    int errors = 0;
    int check_count = 0;
    int seed = 7;
    int div_tab [5] = '{1, 2, 8, 32, 128};
    int model_reload [5];
    int n, p, ch;
    logic [31:0] rd;
    always #20 clk = ~clk;
    // Subclock rises every fourth cycle, so its divided source is 128 cycles.
    always @(posedge clk) begin
        sub_cnt <= sub_cnt + 2'h1;
        subclock <= sub_cnt[1];
    end
    reload_down_timer_unit #(.NUM_CH(5)) i_reload_down_timer_unit (
        .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .subclock(subclock),
        .channel_input_pin(channel_input_pin), .channel_output_pin(channel_output_pin),
        .channel_output_pin_oe(channel_output_pin_oe), .irq(irq));
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        w = 0;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            w++;
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
        chk("bus wait", 1, w);
        @(posedge clk);
    endtask
    // Syncs on one pin toggle, then counts cycles to the next.
    task period(input int c, output int q);
        logic last;
        repeat (2) begin
            last = channel_output_pin[c];
            q = 0;
            do begin
                @(posedge clk);
                q++;
            end while (channel_output_pin[c] === last && q < 2000);
        end
    endtask
    function logic [7:0] ca(input int c);
        return 8'(`CHAN_BASE_OFS + `CHAN_STRIDE * c);
    endfunction
    function logic [31:0] mode(input logic [2:0] src, input logic gate);
        return (32'(src) << `MODE_SRC_LSB) | (32'h1 << `MODE_PULSE_BIT)
            | (32'(gate) << `MODE_GATE_BIT) | (32'(gate) << `MODE_GPOL_BIT);
    endfunction
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        for (int a = 0; a <= 'h48; a += 4) begin
            bus(0, 8'(a), 0);
            chk("reset read", 0, rd);
        end
        $display("reset test done");
        bus(1, `IRQ_MASK_OFS, 32'h1F);
        // Channel c runs from source code c, so every channel and source is used.
        for (ch = 0; ch < 5; ch++) begin
            n = (ch < 3) ? 3 + ($random(seed) & 7) : 1 + ($random(seed) & 3);
            model_reload[ch] = n;
            bus(1, ca(ch) + `CHAN_MODE_DELTA, mode(3'(ch), 0));
            bus(0, ca(ch) + `CHAN_MODE_DELTA, 0);
            chk("mode read", mode(3'(ch), 0), rd);
            bus(1, ca(ch), n);
            bus(0, ca(ch), 0);
            chk("count load", model_reload[ch], rd);
            bus(1, `START_FLAG_OFS, 32'h1 << ch);
            chk("pin drive", 1, channel_output_pin_oe[ch]);
            period(ch, p);
            chk("period", div_tab[ch] * (model_reload[ch] + 1), p);
            bus(0, `START_FLAG_OFS, 0);
            chk("start read", 32'h1 << ch, rd);
            bus(0, `CHAN_STATE_OFS, 0);
            chk("started", 32'h1 << ch, rd);
            bus(1, `START_FLAG_OFS, 0);
            repeat (3) @(posedge clk);
            chk("stopped pin", 0, channel_output_pin);
            chk("irq raised", 1, irq);
            bus(1, `IRQ_MASK_OFS, 0);
            repeat (2) @(posedge clk);
            chk("irq masked", 0, irq);
            bus(1, `IRQ_MASK_OFS, 32'h1F);
            bus(0, `IRQ_STATUS_OFS, 0);
            chk("status", 32'h1 << ch, rd);
            repeat (2) @(posedge clk);
            chk("irq cleared", 0, irq);
            $display("channel %0d test done", ch);
        end
        for (int op = 1; op < 4; op++) begin
            bus(1, ca(0) + `CHAN_MODE_DELTA, mode(`SRC_DIV1, 0) | 32'(op));
            bus(1, ca(0), 5);
            bus(1, `START_FLAG_OFS, 1);
            repeat (10) @(posedge clk);
            bus(0, ca(0), 0);
            chk("held count", 5, rd);
            bus(1, `START_FLAG_OFS, 0);
        end
        $display("mode test done");
        bus(1, ca(0) + `CHAN_MODE_DELTA, mode(`SRC_DIV1, 0));
        bus(1, ca(0), 7);
        bus(1, `START_FLAG_OFS, 1);
        period(0, p);
        model_reload[0] = 200;
        bus(1, ca(0), 200);
        bus(0, ca(0), 0);
        chk("running write", 1, rd <= 7);
        period(0, p);
        chk("new period", model_reload[0] + 1, p);
        bus(1, `START_FLAG_OFS, 0);
        $display("reload test done");
        bus(1, ca(1) + `CHAN_MODE_DELTA, mode(`SRC_DIV1, 1));
        bus(1, ca(1), 4);
        bus(1, `START_FLAG_OFS, 2);
        repeat (20) @(posedge clk);
        bus(0, ca(1), 0);
        chk("gated count", 4, rd);
        channel_input_pin <= 5'h02;
        period(1, p);
        chk("gate open period", 5, p);
        bus(0, `PIN_LEVEL_OFS, 0);
        chk("pin level", 32'h2, rd);
        channel_input_pin <= 5'h00;
        bus(1, `START_FLAG_OFS, 0);
        $display("gate test done");
        complete_run();
    end
endmodule // test_reload_down_timer_unit
`default_nettype wire
